// ---- hb_diag_pkg.sv ----
// constants shared by the serial control and the per-bridge driver logic
package hb_diag_pkg;
    // frame length and chain step in bits
    localparam int FRAME_BITS = 16;
    localparam int CHAIN_STEP = 8;
    localparam int BRIDGES = 6;
    // command frame fields
    localparam int CMD_FAULT_CLEAR = 15;
    localparam int CMD_UNDERLOAD_SHUTDOWN = 13;
    localparam int CMD_ENABLE_LSB = 7;
    localparam int CMD_SIDE_LSB = 1;
    localparam int CMD_OVERVOLTAGE_LOCKOUT_EN_EN = 0;
    // diagnostic frame fields
    localparam int DIAG_OVERCURRENT = 15;
    localparam int DIAG_SUPPLY = 14;
    localparam int DIAG_UNDERLOAD = 13;
    localparam int DIAG_STATUS_LSB = 1;
    localparam int DIAG_THERMAL_WARN = 0;
    // reset values
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [15:0] SHIFT_RESET = 16'h0000;
    // per-bridge status codes
    localparam logic [1:0] ST_DISABLED = 2'h0;
    localparam logic [1:0] ST_OVERCURRENT = 2'h1;
    localparam logic [1:0] ST_UNDERLOAD = 2'h2;
    localparam logic [1:0] ST_ENABLED = 2'h3;
    // dead time between switching sides, a plain default
    localparam int CLK_MHZ = 100;
    localparam int DEADTIME_NS = 1000;
    localparam int DEADTIME_CYC = (DEADTIME_NS * CLK_MHZ + 999) / 1000;
endpackage : hb_diag_pkg

// ---- bridge_ctl.sv ----
// one half bridge: fault latches, priority status and interlocked drive
`timescale 1ns/1ps
module bridge_ctl
    import hb_diag_pkg::*;
#(
    parameter int DT_CYC = DEADTIME_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic bridge_enable,
    input wire logic bridge_side_select,
    input wire logic underload_shutdown_ctl,
    input wire logic drive_allow,
    input wire logic oc_event,
    input wire logic ul_event,
    output logic hs_on,
    output logic ls_on,
    output logic oc_latched,
    output logic ul_latched,
    output logic [1:0] bridge_status_code
);
    typedef struct packed {
        logic hs;
        logic ls;
        logic oc;
        logic ul;
        logic [15:0] dt;
        logic [1:0] st;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic off_latch;
    logic want_hs;
    logic want_ls;

    // next state of latches, drive and status
    always_comb begin
        s_d = s_q;
        // set wins over clear; underload never overrides overcurrent
        // overcurrent takes over
        s_d.oc = (oc_event & (s_q.hs | s_q.ls)) | (s_q.oc & ~clear);
        s_d.ul = (ul_event & (s_q.hs | s_q.ls) & ~s_q.oc & ~oc_event) | (s_q.ul & ~clear);
        off_latch = s_q.oc | (s_q.ul & underload_shutdown_ctl);
        // stays on until a cause removes it
        want_hs = bridge_enable & bridge_side_select & drive_allow & ~off_latch;
        want_ls = bridge_enable & ~bridge_side_select & drive_allow & ~off_latch;
        // break before make with dead time
        if (s_q.hs && !want_hs) begin
            s_d.hs = 1'b0;
            s_d.dt = 16'(DT_CYC);
        end else if (s_q.ls && !want_ls) begin
            s_d.ls = 1'b0;
            s_d.dt = 16'(DT_CYC);
        end else if (s_q.dt != 16'h0000) begin
            s_d.dt = s_q.dt - 16'h0001;
        end else if (want_hs && !s_q.ls) begin
            s_d.hs = 1'b1;
        end else if (want_ls && !s_q.hs) begin
            s_d.ls = 1'b1;
        end
        if (s_q.oc) begin
            s_d.st = ST_OVERCURRENT;
        end else if (s_q.ul) begin
            s_d.st = ST_UNDERLOAD;
        end else if (bridge_enable) begin
            s_d.st = ST_ENABLED;
        end else begin
            s_d.st = ST_DISABLED;
        end
    end

    // single register for all state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign hs_on = s_q.hs;
    assign ls_on = s_q.ls;
    assign oc_latched = s_q.oc;
    assign ul_latched = s_q.ul;
    assign bridge_status_code = s_q.st;

    a_no_shoot_through: assert property (@(posedge clk) disable iff (rst) !(s_q.hs && s_q.ls))
        else $error("both switches of one bridge on");
    a_deadtime_wait: assert property (@(posedge clk) disable iff (rst)
        $rose(s_q.ls) |-> $past(s_q.dt) == 16'h0000 && !$past(s_q.hs))
        else $error("low side turned on without dead time");
    a_oc_priority: assert property (@(posedge clk) disable iff (rst) s_q.oc |=> s_q.st == ST_OVERCURRENT)
        else $error("overcurrent not reported");
    a_oc_not_to_ul: assert property (@(posedge clk) disable iff (rst)
        s_q.st == ST_OVERCURRENT && !clear |=> s_q.st != ST_UNDERLOAD)
        else $error("status moved from overcurrent to underload");
    c_oc_after_ul: cover property (@(posedge clk) disable iff (rst)
        s_q.st == ST_UNDERLOAD ##1 s_q.st == ST_OVERCURRENT);
endmodule : bridge_ctl

// ---- hb_spi_diag.sv ----
// serial command and diagnostic logic for a six channel half bridge driver
`timescale 1ns/1ps
module hb_spi_diag
    import hb_diag_pkg::*;
#(
    parameter int NB = BRIDGES,
    parameter int DT_CYC = DEADTIME_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic si,
    output logic so,
    output logic so_oe_n,
    input wire logic [NB-1:0] overcurrent_in,
    input wire logic [NB-1:0] underload_in,
    input wire logic thermal_shutdown_in,
    input wire logic thermal_warn_in,
    input wire logic load_supply_uv,
    input wire logic load_supply_ov,
    input wire logic logic_supply_uv,
    output logic [NB-1:0] high_side_on,
    output logic [NB-1:0] low_side_on,
    output logic [15:0] command_word
);
    localparam int SW = 8 + 2 * NB;

    typedef struct packed {
        logic [SW-1:0] s1;
        logic [SW-1:0] s2;
        logic sclk_p;
        logic cs_p;
        logic [15:0] sr;
        logic [4:0] cnt;
        logic pre;
        logic so;
        logic [15:0] cmd;
        logic tsd;
        logic clr;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic sclk_s, cs_s, si_s, tsd_s, tw_s, vsuv_s, vsov_s, vccuv_s;
    logic [NB-1:0] oc_s, ul_s;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, frame_ok;
    logic drive_allow, oc_flag, ul_flag, supply_fault_flag;
    logic [NB-1:0] oc_lat, ul_lat;
    logic [2*NB-1:0] st_all;
    logic [15:0] diag;

    assign {ul_s, oc_s, vccuv_s, vsov_s, vsuv_s, tw_s, tsd_s, si_s, cs_s, sclk_s} = s_q.s2;

    // edges found on the synchronised serial pins
    assign sclk_rise = sclk_s & ~s_q.sclk_p;
    assign sclk_fall = ~sclk_s & s_q.sclk_p;
    assign cs_fall = ~cs_s & s_q.cs_p;
    assign cs_rise = cs_s & ~s_q.cs_p;
    // count folds 24 back to 16, so 16 means legal
    assign frame_ok = s_q.cnt == 5'(FRAME_BITS);

    // global flags and the diagnostic word
    assign oc_flag = |oc_lat;
    assign ul_flag = |ul_lat;
    assign supply_fault_flag = vsuv_s | vsov_s;
    always_comb begin
        diag = '0;
        diag[DIAG_OVERCURRENT] = oc_flag;
        diag[DIAG_SUPPLY] = supply_fault_flag;
        diag[DIAG_UNDERLOAD] = ul_flag;
        diag[DIAG_THERMAL_WARN] = tw_s;
        diag[DIAG_STATUS_LSB +: 2*NB] = st_all;
    end

    // load supply gating keeps the programmed command; logic undervoltage clears it
    assign drive_allow = ~vsuv_s & ~(s_q.cmd[CMD_OVERVOLTAGE_LOCKOUT_EN_EN] & vsov_s) & ~s_q.tsd & ~vccuv_s;

    // serial engine, frame check and command register
    always_comb begin
        s_d = s_q;
        s_d.s1 = {underload_in, overcurrent_in, logic_supply_uv, load_supply_ov, load_supply_uv,
                  thermal_warn_in, thermal_shutdown_in, si, chip_select_n, sclk};
        s_d.s2 = s_q.s1;
        s_d.sclk_p = sclk_s;
        s_d.cs_p = cs_s;
        s_d.clr = 1'b0;
        // thermal shutdown latch, set wins over clear
        s_d.tsd = tsd_s | s_q.tsd;
        if (cs_fall) begin
            // previous state goes out in this frame
            s_d.sr = diag;
            s_d.cnt = '0;
            s_d.pre = 1'b1;
        end else if (!cs_s) begin
            // out on rise, in on fall, msb first
            if (sclk_rise) begin
                s_d.so = s_q.sr[15];
                s_d.pre = 1'b0;
            end
            if (sclk_fall) begin
                s_d.sr = {s_q.sr[14:0], si_s};
                // first 16, then steps of 8
                s_d.cnt = (s_q.cnt == 5'(FRAME_BITS + CHAIN_STEP - 1)) ? 5'(FRAME_BITS) : s_q.cnt + 5'h01;
            end
        end
        if (cs_rise && frame_ok) begin
            s_d.cmd = s_q.sr;
            s_d.clr = s_q.sr[CMD_FAULT_CLEAR];
            if (s_q.sr[CMD_FAULT_CLEAR] && !tsd_s) begin
                s_d.tsd = 1'b0;
            end
        end
        if (cs_s) begin
            s_d.pre = 1'b0;
        end
        if (vccuv_s) begin
            s_d.sr = SHIFT_RESET;
            s_d.cmd = CMD_RESET;
            s_d.cnt = '0;
            s_d.pre = 1'b0;
            s_d.so = 1'b0;
            s_d.tsd = 1'b0;
            s_d.clr = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            // select idles high; a zero here would fake a select edge after reset
            s_q.s1[1] <= 1'b1;
            s_q.s2[1] <= 1'b1;
            s_q.cs_p <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // thermal bit ORed with the input before the first rise
    assign so = s_q.pre ? (s_q.tsd | si_s) : s_q.so;
    assign so_oe_n = cs_s;
    assign command_word = s_q.cmd;

    // enable and side fields of each bridge
    generate
        for (genvar i = 0; i < NB; i++) begin : g_br
            bridge_ctl #(.DT_CYC(DT_CYC)) u_br (
                .clk(clk),
                .rst(rst),
                .clear(s_q.clr),
                .bridge_enable(s_q.cmd[CMD_ENABLE_LSB + i]),
                .bridge_side_select(s_q.cmd[CMD_SIDE_LSB + i]),
                .underload_shutdown_ctl(s_q.cmd[CMD_UNDERLOAD_SHUTDOWN]),
                .drive_allow(drive_allow),
                .oc_event(oc_s[i]),
                .ul_event(ul_s[i]),
                .hs_on(high_side_on[i]),
                .ls_on(low_side_on[i]),
                .oc_latched(oc_lat[i]),
                .ul_latched(ul_lat[i]),
                .bridge_status_code(st_all[2*i +: 2])
            );
        end
    endgenerate

    a_so_released: assert property (@(posedge clk) disable iff (rst) cs_s |-> so_oe_n ##1 !s_q.pre)
        else $error("serial output driven while deselected");
    a_pre_bit: assert property (@(posedge clk) disable iff (rst)
        cs_fall && !vccuv_s |=> s_q.pre && so == (s_q.tsd | si_s))
        else $error("thermal bit not shown after select fall");
    a_pre_hold: assert property (@(posedge clk) disable iff (rst)
        s_q.pre && !sclk_rise && !cs_s && !cs_fall && !vccuv_s |=> s_q.pre)
        else $error("thermal bit dropped before first rise");
    a_frame_discard: assert property (@(posedge clk) disable iff (rst)
        cs_rise && !frame_ok && !vccuv_s |=> $stable(s_q.cmd))
        else $error("bad frame changed the command");
    a_frame_load: assert property (@(posedge clk) disable iff (rst)
        cs_rise && frame_ok && !vccuv_s |=> s_q.cmd == $past(s_q.sr))
        else $error("legal frame not loaded");
    a_uv_drivers_off: assert property (@(posedge clk) disable iff (rst)
        vsuv_s [*3] |-> high_side_on == '0 && low_side_on == '0)
        else $error("drivers on during load undervoltage");
    a_uv_cmd_kept: assert property (@(posedge clk) disable iff (rst)
        vsuv_s && !vccuv_s && !cs_rise |=> $stable(s_q.cmd))
        else $error("command lost in load undervoltage");
    a_psf_report: assert property (@(posedge clk) disable iff (rst)
        cs_fall && !vccuv_s |=> s_q.sr[DIAG_SUPPLY] == $past(supply_fault_flag))
        else $error("supply flag not loaded");
    a_vcc_clear: assert property (@(posedge clk) disable iff (rst)
        vccuv_s |=> s_q.cmd == CMD_RESET ##1 high_side_on == '0 && low_side_on == '0)
        else $error("logic undervoltage did not clear");

    c_frame_16: cover property (@(posedge clk) disable iff (rst) cs_rise && frame_ok && s_q.cnt == 5'h10);
    c_frame_error: cover property (@(posedge clk) disable iff (rst) cs_rise && !frame_ok);
    c_thermal_pre: cover property (@(posedge clk) disable iff (rst) s_q.pre && s_q.tsd);
    c_fault_clear: cover property (@(posedge clk) disable iff (rst) s_q.clr && oc_flag);
endmodule : hb_spi_diag

// ---- spi_master_model.sv ----
// serial master model that drives the control link of the bridge driver
`timescale 1ns/1ps
module spi_master_model (
    input wire logic clk,
    input wire logic so,
    input wire logic so_oe_n,
    output logic sclk,
    output logic chip_select_n,
    output logic si
);
    logic so_seen;
    // a released output carries no data; the inverse makes a late enable visible
    assign so_seen = so_oe_n ? ~so : so;
    // idle link: select high, clock and data driven low
    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        si = 1'b0;
    end
    // wait system clocks, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // one select cycle of n bits, msb first; rx collects what comes back
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx, output logic pre);
        rx = 32'h0;
        sclk = 1'b0;
        si = 1'b0;
        tick(2);
        chip_select_n = 1'b0;
        tick(8);
        pre = so_seen;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b1;
            tick(6);
            rx = {rx[30:0], so_seen};
            si = tx[i];
            tick(2);
            sclk = 1'b0;
            tick(8);
        end
        tick(4);
        si = 1'b0;
        chip_select_n = 1'b1;
    endtask : xfer
endmodule : spi_master_model

// ---- half_bridge_spi_diag_control_tb.sv ----
// self-checking bench for the serial control and diagnostic block
`timescale 1ns/1ps
module half_bridge_spi_diag_control_tb;
    import hb_diag_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sclk, chip_select_n, si, so, so_oe_n, pre;
    logic [5:0] oc_in = 6'h00;
    logic [5:0] ul_in = 6'h00;
    logic tsd_in = 1'b0;
    logic tw_in = 1'b0;
    logic vs_uv = 1'b0;
    logic vs_ov = 1'b0;
    logic vcc_uv = 1'b0;
    logic [5:0] hs, ls;
    logic [15:0] command_word;
    logic [31:0] rx;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    // bridges 6..1 alternate sides, then the opposite pattern
    localparam logic [31:0] CMD_A = 32'h0000_1FD4;
    localparam logic [31:0] CMD_B = 32'h0000_1FAA;
    always #5 clk = ~clk;
    hb_spi_diag #(.DT_CYC(2)) u_dut (.clk(clk), .rst(rst), .sclk(sclk), .chip_select_n(chip_select_n),
        .si(si), .so(so), .so_oe_n(so_oe_n), .overcurrent_in(oc_in), .underload_in(ul_in),
        .thermal_shutdown_in(tsd_in), .thermal_warn_in(tw_in), .load_supply_uv(vs_uv),
        .load_supply_ov(vs_ov), .logic_supply_uv(vcc_uv), .high_side_on(hs), .low_side_on(ls),
        .command_word(command_word));
    spi_master_model u_master (.clk(clk), .so(so), .so_oe_n(so_oe_n), .sclk(sclk),
        .chip_select_n(chip_select_n), .si(si));
    task automatic stop_test();
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // one frame, then time for load, dead time and drivers to settle
    task automatic frame(input int n, input logic [31:0] tx);
        u_master.xfer(n, tx, rx, pre);
        tick(24);
    endtask : frame
    task automatic drv(input logic [5:0] h, input logic [5:0] l);
        check("high_side_on", 32'(hs), 32'(h));
        check("low_side_on", 32'(ls), 32'(l));
    endtask : drv
    // cut a hang short; a frame is about 300 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            stop_test();
        end
    end
    // shoot-through guard watched every cycle, away from the launching edge
    always @(negedge clk) begin
        if (!rst) begin
            check("interlock", 32'(hs & ls), 32'h0);
        end
    end
    initial begin
        tick(8);
        rst = 1'b0;
        tick(6);
        check("command_word", 32'(command_word), 32'h0);
        drv(6'h00, 6'h00);
        check("so_oe_n", 32'(so_oe_n), 32'h1);
        frame(16, CMD_A);
        check("command_word", 32'(command_word), CMD_A);
        drv(6'h2A, 6'h15);
        tw_in = 1'b1;
        frame(16, CMD_A);
        check("diag", rx, 32'h1FFF);
        check("pre_bit", 32'(pre), 32'h0);
        frame(15, 32'h0);
        frame(20, 32'h0);
        check("command_word", 32'(command_word), CMD_A);
        drv(6'h2A, 6'h15);
        // 24 bits: last 16 load, first byte leaves behind the diagnostic word
        frame(24, {8'h0, 8'hA5, CMD_B[15:0]});
        check("diag_chain", rx, 32'h1FFFA5);
        check("command_word", 32'(command_word), CMD_B);
        drv(6'h15, 6'h2A);
        vs_uv = 1'b1;
        tick(10);
        drv(6'h00, 6'h00);
        frame(16, CMD_B);
        check("diag_uv", rx, 32'h5FFF);
        check("command_word", 32'(command_word), CMD_B);
        vs_uv = 1'b0;
        tick(10);
        drv(6'h15, 6'h2A);
        frame(16, CMD_B);
        check("diag_uv_gone", rx, 32'h1FFF);
        // overvoltage with lockout on stops the drivers; lockout off lets them resume
        frame(16, CMD_B | 32'h0001);
        vs_ov = 1'b1;
        tick(10);
        drv(6'h00, 6'h00);
        frame(16, CMD_B);
        check("diag_ov", rx, 32'h5FFF);
        drv(6'h15, 6'h2A);
        vs_ov = 1'b0;
        oc_in[0] = 1'b1;
        tick(10);
        oc_in[0] = 1'b0;
        ul_in[0] = 1'b1;
        tick(10);
        drv(6'h14, 6'h2A);
        frame(16, CMD_B | 32'h8000);
        check("diag_oc", rx, 32'h9FFB);
        // underload shutdown off, so the bridge keeps driving with underload latched
        frame(16, CMD_B & 32'hDFFF);
        check("diag_ul", rx, 32'h3FFD);
        drv(6'h15, 6'h2A);
        oc_in[0] = 1'b1;
        tick(10);
        frame(16, CMD_B);
        check("diag_ul_oc", rx, 32'hBFFB);
        oc_in[0] = 1'b0;
        ul_in[0] = 1'b0;
        tsd_in = 1'b1;
        tick(10);
        drv(6'h00, 6'h00);
        frame(16, CMD_B);
        check("pre_bit", 32'(pre), 32'h1);
        tsd_in = 1'b0;
        vcc_uv = 1'b1;
        tick(10);
        check("command_word", 32'(command_word), 32'h0);
        drv(6'h00, 6'h00);
        vcc_uv = 1'b0;
        tick(10);
        frame(16, CMD_B);
        check("pre_bit", 32'(pre), 32'h0);
        check("diag_cleared", rx, 32'h0001);
        check("command_word", 32'(command_word), CMD_B);
        drv(6'h15, 6'h2A);
        stop_test();
    end
endmodule : half_bridge_spi_diag_control_tb
